// >>> hw/ppar_pkg.sv
// ppar_pkg: constants and carrier types for the parallel port address block
// assumes an apb slave with 32-bit data and word-aligned registers
package ppar_pkg;
  localparam logic [11:0] OFS_ADDR        = 12'h000;
  localparam logic [11:0] OFS_MODE        = 12'h004;
  localparam logic [11:0] OFS_CTRL        = 12'h008;
  localparam logic [11:0] OFS_STAT        = 12'h00c;
  localparam int          ADDR_W          = 11;
  localparam int          CHIP_SEL_POS    = 14;
  localparam logic [15:0] ADDR_RST        = 16'h0000;
  localparam logic [15:0] ADDR_MASK       = 16'h47ff;
  // mode register fields
  localparam int          HOLD_WAIT_LSB   = 0;
  localparam int          STRB_CNT_LSB    = 2;
  localparam int          SETUP_WAIT_LSB  = 6;
  localparam logic [15:0] MODE_MASK       = 16'h00ff;
  localparam logic [15:0] MODE_RST        = 16'h0000;
  localparam logic [3:0]  STRB_CNT_NONE   = 4'h0;
  // control register: bit0 starts a transfer
  localparam int          CTRL_GO_POS     = 0;
  localparam logic [31:0] CTRL_GO_MASK    = 32'h0000_0001;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              first_chip_select_bit;
  } ppar_pins_s;

  typedef struct packed {
    logic [1:0] setup;
    logic [3:0] strobe;
    logic [1:0] hold;
  } ppar_wait_s;
endpackage

// >>> hw/ppar_addr.sv
// ppar_addr: address and chip-select holding register of a parallel port,
// with a simple wait-state sequencer that frames each transfer
// assumes an apb master on clk; pin drivers sit outside this module
//
// Functional notes
// - a strobe wait count of zero makes the setup and hold waits ignored.
// - bit 14 of the address register is a chip select, one active, reset 0.
// - bits 10 to 0 hold the destination address, reset to zero.
// - on the small package only the two lowest address lines reach pins.
`timescale 1ns/10ps
module ppar_addr #(
  parameter bit SMALL_PKG = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output ppar_pkg::ppar_pins_s       pins,
  output logic      [10:0]           pins_oe,
  output logic                       strobe,
  output logic                       busy
);
  import ppar_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_STRB  = 2'b10,
    ST_HOLD  = 2'b11
  } ppar_state_e;

  logic [15:0] addr_reg_ff;
  logic [15:0] mode_reg_ff;
  ppar_state_e state_ff;
  logic [3:0]  cnt_ff;
  ppar_pins_s  pins_ff;
  logic        strobe_ff;
  logic        nxt_strobe;
  logic        wr_en;
  logic        go;
  ppar_wait_s  wt;
  ppar_wait_s  wt_ff;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  // only the four word offsets are decoded; anything else is refused
  function automatic logic is_mapped(input logic [11:0] a);
    if (hit(a, OFS_ADDR)) begin
      is_mapped = 1'b1;
    end else if (hit(a, OFS_MODE)) begin
      is_mapped = 1'b1;
    end else if (hit(a, OFS_CTRL)) begin
      is_mapped = 1'b1;
    end else if (hit(a, OFS_STAT)) begin
      is_mapped = 1'b1;
    end else begin
      is_mapped = 1'b0;
    end
  endfunction

  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign wt      = ppar_wait_s'(mode_reg_ff[7:0]);
  assign go      = wr_en && hit(paddr, OFS_CTRL) && pwdata[CTRL_GO_POS]
                   && (state_ff == ST_IDLE);

  // unmapped addresses answer with an error, no side effect
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      if (is_mapped(paddr)) begin
        pslverr = 1'b0;
      end else begin
        pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_reg_ff <= ADDR_RST;
    end else if (wr_en && hit(paddr, OFS_ADDR)) begin
      addr_reg_ff <= pwdata[15:0] & ADDR_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg_ff <= MODE_RST;
    end else if (wr_en && hit(paddr, OFS_MODE)) begin
      mode_reg_ff <= pwdata[15:0] & MODE_MASK;
    end
  end

  // wait settings are taken at the start of a transfer, so a mode write
  // during a frame cannot stretch or cut it
  always_ff @(posedge clk) begin
    if (srst) begin
      wt_ff <= '0;
    end else if (go) begin
      wt_ff <= wt;
    end
  end

  // registered read data, taken in the setup cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      if (hit(paddr, OFS_ADDR)) begin
        prdata <= {16'h0000, addr_reg_ff};
      end else if (hit(paddr, OFS_MODE)) begin
        prdata <= {16'h0000, mode_reg_ff};
      end else if (hit(paddr, OFS_STAT)) begin
        prdata <= {28'h0000000, cnt_ff[1:0], state_ff};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // sequencer: setup, strobe, hold phases; one-cycle waits are counted
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 4'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (go) begin
            if (wt.strobe == STRB_CNT_NONE) begin
              state_ff <= ST_STRB;
              cnt_ff   <= 4'h0;
            end else begin
              state_ff <= ST_SETUP;
              cnt_ff   <= {2'b00, wt.setup};
            end
          end
        end
        ST_SETUP: begin
          if (cnt_ff == 4'h0) begin
            state_ff <= ST_STRB;
            cnt_ff   <= wt_ff.strobe;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_STRB: begin
          if (cnt_ff == 4'h0) begin
            if (wt_ff.strobe == STRB_CNT_NONE) begin
              state_ff <= ST_IDLE;
            end else begin
              state_ff <= ST_HOLD;
              cnt_ff   <= {2'b00, wt_ff.hold};
            end
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_HOLD: begin
          if (cnt_ff == 4'h0) begin
            state_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // strobe is high exactly while the sequencer sits in its strobe phase;
  // it is taken from the next state so it lines up with state_ff
  always_comb begin
    nxt_strobe = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        nxt_strobe = go && (wt.strobe == STRB_CNT_NONE);
      end
      ST_SETUP: begin
        nxt_strobe = (cnt_ff == 4'h0);
      end
      ST_STRB: begin
        nxt_strobe = (cnt_ff != 4'h0);
      end
      ST_HOLD: begin
        nxt_strobe = 1'b0;
      end
      default: begin
        nxt_strobe = 1'b0;
      end
    endcase
  end

  // pins follow the register; address lines are only valid while busy
  always_ff @(posedge clk) begin
    if (srst) begin
      pins_ff   <= '0;
      strobe_ff <= 1'b0;
    end else begin
      pins_ff.addr <= addr_reg_ff[ADDR_W-1:0];
      pins_ff.first_chip_select_bit <= addr_reg_ff[CHIP_SEL_POS];
      strobe_ff    <= nxt_strobe;
    end
  end

  assign pins   = pins_ff;
  assign strobe = strobe_ff;
  assign busy   = (state_ff != ST_IDLE);

  // small package has no upper lines; they are never enabled
  always_comb begin
    pins_oe = 11'h000;
    if (busy) begin
      pins_oe = SMALL_PKG ? 11'h003 : 11'h7ff;
    end
  end
endmodule // ppar_addr

// >>> tb/ppar_addr_asserts.sv
// ppar_addr_asserts: port checks of the address block
// assumes binding into ppar_addr, all ports seen by name
`timescale 1ns/10ps
module ppar_addr_asserts #(
  parameter bit SMALL_PKG = 1'b0
) (
  input wire logic                 clk,
  input wire logic                 srst,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire ppar_pkg::ppar_pins_s pins,
  input wire logic [10:0]          pins_oe,
  input wire logic                 strobe,
  input wire logic                 busy
);
  import ppar_pkg::*;
  logic zero_ff;
  wire  acc = psel && penable && pwrite;
  // mode tracked here, so no mode writes while busy
  always_ff @(posedge clk) begin
    if (srst) zero_ff <= 1'b1;
    else if (acc && paddr == OFS_MODE)
      zero_ff <= pwdata[STRB_CNT_LSB +: 4] == STRB_CNT_NONE;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_wr; acc && paddr == OFS_ADDR; endsequence
  sequence s_go; $rose(strobe); endsequence
  a_addr_lands: assert property (s_wr |=> ##1
    pins.addr == $past(pwdata[10:0], 2)) else $error("address pins wrong");
  a_cs_lands: assert property (s_wr |=> ##1
    pins.first_chip_select_bit == $past(pwdata[CHIP_SEL_POS], 2))
    else $error("chip select wrong");
  a_short_strobe: assert property (s_go and zero_ff |=> !strobe)
    else $error("strobe too long");
  a_long_strobe: assert property (s_go and !zero_ff |=> strobe)
    else $error("strobe too short");
  a_oe_width: assert property (pins_oe == (busy ?
    (SMALL_PKG ? 11'h003 : 11'h7ff) : 11'h000)) else $error("bad enables");
endmodule // ppar_addr_asserts
bind ppar_addr ppar_addr_asserts #(.SMALL_PKG(SMALL_PKG)) chk_u (.*);

// >>> tb/ppar_peer.sv
// ppar_peer: far-side device latching the address at each strobe
// assumes undriven lines float, seen as the inverse of the last level
`timescale 1ns/10ps
module ppar_peer (
  input  wire logic                 clk,
  input  wire logic                 strobe,
  input  wire ppar_pkg::ppar_pins_s pins,
  input  wire logic [10:0]          oe,
  output logic                      hit,
  output logic [11:0]               got
);
  import ppar_pkg::*;
  logic [10:0] lv_ff = 11'h000;
  logic        st_ff = 1'b0;
  wire  [10:0] lv = (oe & pins.addr) | (~oe & ~lv_ff);
  always_ff @(posedge clk) begin
    lv_ff <= (oe & pins.addr) | (~oe & lv_ff);
    st_ff <= strobe;
    hit   <= strobe & ~st_ff;
    got   <= {pins.first_chip_select_bit, lv};
  end
endmodule // ppar_peer

// >>> tb/parallel_port_address_register_tb_top.sv
// bench: apb writes and reads, transfers seen by the peer model
// assumes pready tied high and one transfer in flight at a time
`timescale 1ns/10ps
module parallel_port_address_register_tb_top;
  import ppar_pkg::*;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000, got;
  logic [31:0] pwdata = 32'h0, prdata, w, m;
  logic pready, pslverr, strobe, busy, hit;
  logic [10:0] pins_oe, oe_s;
  logic [32:0] e, qr[$];
  logic [11:0] qp[$];
  ppar_pins_s pins;
  int num_errors = 0, num_checks = 0, seed = 5, n, k;
  ppar_addr #(.SMALL_PKG(1'b0)) dut_u (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .pins_oe(pins_oe), .strobe(strobe), .busy(busy));
  ppar_peer peer_u (.clk(clk), .strobe(strobe), .pins(pins), .oe(pins_oe),
    .hit(hit), .got(got));
  ppar_addr #(.SMALL_PKG(1'b1)) small_u (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(), .pready(), .pslverr(), .pins(), .pins_oe(oe_s), .strobe(),
    .busy());
  initial forever #5 clk = ~clk;
  task automatic chk(input logic ok);
    num_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t result differs", $time);
    end
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    qr.push_back(x);
    xfer(0, a, 32'h0);
  endtask
  // reads are judged where the answer is sampled, not in the driver
  always @(posedge clk) if (psel && penable && !pwrite && pready === 1'b1) begin
    e = qr.pop_front();
    chk(pslverr === e[32] && (e[32] || prdata === e[31:0]));
  end
  always @(posedge clk) if (hit === 1'b1) chk(got === qp.pop_front());
  always @(negedge clk) if (busy === 1'b1)
    chk(pins_oe === 11'h7ff && oe_s === 11'h003);
  initial begin
    #20000 chk(1'b0);
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    rd(OFS_ADDR, 33'h0);
    rd(12'h010, 33'h1_0000_0000);
    rd(OFS_STAT, 33'h0);
    rd(OFS_CTRL, 33'h0);
    for (n = 0; n < 12; n++) begin
      w = $random(seed);
      m = $random(seed);
      if (!n[0]) m[STRB_CNT_LSB +: 4] = STRB_CNT_NONE;
      else m[STRB_CNT_LSB] = 1'b1;
      xfer(1, OFS_ADDR, w);
      rd(OFS_ADDR, {1'b0, w & {16'h0, ADDR_MASK}});
      xfer(1, OFS_MODE, m);
      rd(OFS_MODE, {1'b0, m & {16'h0, MODE_MASK}});
      qp.push_back({w[CHIP_SEL_POS], w[10:0]});
      xfer(1, OFS_CTRL, CTRL_GO_MASK);
      // a second start while busy must be refused: no extra peer strobe
      if (n[0]) xfer(1, OFS_CTRL, CTRL_GO_MASK);
      for (k = 0; k < 40 && busy !== 1'b0; k++) @(negedge clk);
      chk(busy === 1'b0);
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
    give_verdict;
  end
endmodule // parallel_port_address_register_tb_top
